// *** hw/pdt_regs.sv ***
// Purpose: APB register bank for the first-Tari length and PLL divider settings.
// Assumes: APB master keeps the request steady until PREADY; CE_IN freezes all state.
// Notes: Every access takes one wait state; results follow a register write by one cycle.
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps

// Summary of operation
// - An 8-bit code sets first Tari high length; legal 5Fh to 9Dh.
// - Code step is 50, 100 or 200 ns for Tari 6.25, 12.5, 25 us.
// - Reference select 100..111 gives 125, 100, 50, 25 kHz; others forbidden.
// - Each divider ratio is B times 32 plus A times 33.
// - Main B and A counts are split over registers 17h, 18h and 19h.
// - Auxiliary B and A high bits sit in registers 1Ah and 1Bh.
// - Register 1Ch holds the low eight bits of auxiliary A.
module pdt_regs (
	input wire logic CLK_IN, // 10 MHz clock.
	input wire logic RST_IN, // Asynchronous reset, active high.
	input wire logic CE_IN, // Clock enable; low freezes all state.
	input wire logic PSEL_IN, // APB select.
	input wire logic PENABLE_IN, // APB enable.
	input wire logic PWRITE_IN, // APB direction, high for write.
	input wire logic [pdt_pkg::PDT_AW-1:0] PADDR_IN, // APB byte address.
	input wire logic [pdt_pkg::PDT_DW-1:0] PWDATA_IN, // APB write data.
	input wire logic [3:0] PSTRB_IN, // APB byte strobes; lane 0 writes.
	output logic PREADY_OUT, // APB ready.
	output logic [pdt_pkg::PDT_DW-1:0] PRDATA_OUT, // APB read data.
	output logic PSLVERR_OUT, // APB error for unmapped or read-only writes.
	output logic [16:0] MAIN_RATIO_OUT, // Main divider ratio.
	output logic [16:0] AUX_RATIO_OUT, // Auxiliary divider ratio.
	output logic [23:0] CARRIER_KHZ_OUT, // Carrier frequency in kHz.
	output logic [14:0] FIRST_TARI_NS_OUT, // First Tari high length in ns.
	output logic [3:0] CFG_ERR_OUT // Configuration error flags.
);
	import pdt_pkg::*;

	pdt_mem_if mbus ();

	pdt_regmem u_mem (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.bus(mbus)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic [5:0] word_idx;
	logic mem_hit;
	logic own_hit;
	logic ro_hit;
	logic [2:0] mem_sel;

	always_comb begin
		word_idx = PADDR_IN[7:2];
		mem_hit = PADDR_IN[1:0] == 2'h0 && word_idx >= IDX_FIRST_TARI && word_idx <= IDX_AUX_A;
		mem_sel = 3'(word_idx - IDX_FIRST_TARI);
		ro_hit = PADDR_IN == ADDR_STATUS || PADDR_IN == ADDR_MAIN_RATIO
			|| PADDR_IN == ADDR_AUX_RATIO || PADDR_IN == ADDR_CARRIER
			|| PADDR_IN == ADDR_TARI_NS;
		own_hit = ro_hit || PADDR_IN == ADDR_CTRL;
	end

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	logic [7:0] first_tari_high_len;
	logic [2:0] pll_ref_divider_sel;
	logic [9:0] main_div_b_count;
	logic [9:0] main_div_a_count;
	logic [9:0] aux_div_b_count;
	logic [9:0] aux_div_a_count;
	logic rsv_set;

	always_comb begin
		first_tari_high_len = mbus.image[7:0];
		pll_ref_divider_sel = mbus.image[8+REF_LSB +: 3];
		main_div_b_count = {mbus.image[11:8], mbus.image[23:18]};
		main_div_a_count = {mbus.image[17:16], mbus.image[31:24]};
		aux_div_b_count = {mbus.image[35:32], mbus.image[47:42]};
		aux_div_a_count = {mbus.image[41:40], mbus.image[55:48]};
		rsv_set = mbus.image[8+RSV_BIT] || mbus.image[39:36] != 4'h0;
	end

	// ----------------------------------------------------------------
	// Result computation
	// ----------------------------------------------------------------
	logic [2:0] ctrl;
	logic [2:0] next_ctrl;
	logic [1:0] tari_mode;
	logic [16:0] next_main_ratio;
	logic [16:0] next_aux_ratio;
	logic [6:0] ref_khz;
	logic [7:0] step_ns;
	logic [23:0] next_carrier;
	logic [14:0] next_tari_ns;
	logic [3:0] next_err;

	always_comb begin
		tari_mode = ctrl[CTRL_MODE_LSB +: 2];
		next_main_ratio = 17'(main_div_b_count) * PRESC_LOW
			+ 17'(main_div_a_count) * PRESC_HIGH;
		next_aux_ratio = 17'(aux_div_b_count) * PRESC_LOW
			+ 17'(aux_div_a_count) * PRESC_HIGH;
		next_err = 4'h0;
		case (pll_ref_divider_sel)
			REF_125K: ref_khz = REF_KHZ_125;
			REF_100K: ref_khz = REF_KHZ_100;
			REF_50K: ref_khz = REF_KHZ_50;
			REF_25K: ref_khz = REF_KHZ_25;
			default: begin
				ref_khz = 7'h00;
				next_err[ST_REF_ILLEGAL] = 1'b1;
			end
		endcase
		// The carrier follows whichever divider software marks active.
		if (ctrl[CTRL_AUX_SEL]) begin
			next_carrier = 24'(ref_khz) * 24'(next_aux_ratio);
		end else begin
			next_carrier = 24'(ref_khz) * 24'(next_main_ratio);
		end
		case (tari_mode)
			TARI_6US25: step_ns = STEP_NS_6US25;
			TARI_12US5: step_ns = STEP_NS_12US5;
			TARI_25US: step_ns = STEP_NS_25US;
			default: begin
				step_ns = STEP_NS_25US;
				next_err[ST_MODE_ILLEGAL] = 1'b1;
			end
		endcase
		next_tari_ns = 15'(first_tari_high_len) * 15'(step_ns);
		next_err[ST_TARI_RANGE] = first_tari_high_len < TARI_CODE_MIN
			|| first_tari_high_len > TARI_CODE_MAX;
		next_err[ST_RSV_SET] = rsv_set;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			MAIN_RATIO_OUT <= 17'h00000;
			AUX_RATIO_OUT <= 17'h00000;
			CARRIER_KHZ_OUT <= 24'h000000;
			FIRST_TARI_NS_OUT <= 15'h0000;
			CFG_ERR_OUT <= 4'h0;
		end else if (CE_IN) begin
			MAIN_RATIO_OUT <= next_main_ratio;
			AUX_RATIO_OUT <= next_aux_ratio;
			CARRIER_KHZ_OUT <= next_carrier;
			FIRST_TARI_NS_OUT <= next_tari_ns;
			CFG_ERR_OUT <= next_err;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	pdt_apb_e state;
	pdt_apb_e next_state;
	logic next_pready;
	logic next_pslverr;
	logic [31:0] next_prdata;
	logic wr_fire;

	// The storage read port is registered, so the answer waits one cycle.
	always_comb begin
		next_state = state;
		next_pready = 1'b0;
		next_pslverr = PSLVERR_OUT;
		next_prdata = PRDATA_OUT;
		next_ctrl = ctrl;
		wr_fire = 1'b0;
		mbus.en = CE_IN;
		mbus.raddr = mem_sel;
		mbus.we = 1'b0;
		mbus.waddr = mem_sel;
		mbus.wdata = PWDATA_IN[7:0];
		case (state)
			PDT_IDLE: begin
				if (PSEL_IN && !PENABLE_IN) begin
					next_state = PDT_FETCH;
				end
			end
			PDT_FETCH: begin
				next_state = PDT_DONE;
				next_pready = 1'b1;
				next_pslverr = !(mem_hit || own_hit) || (PWRITE_IN && ro_hit);
				next_prdata = 32'h00000000;
				if (!PWRITE_IN) begin
					if (mem_hit) begin
						next_prdata = {24'h000000, mbus.rdata};
					end else begin
						case (PADDR_IN)
							ADDR_CTRL: next_prdata = {29'h00000000, ctrl};
							ADDR_STATUS: next_prdata = {28'h0000000, CFG_ERR_OUT};
							ADDR_MAIN_RATIO: next_prdata = {15'h0000, MAIN_RATIO_OUT};
							ADDR_AUX_RATIO: next_prdata = {15'h0000, AUX_RATIO_OUT};
							ADDR_CARRIER: next_prdata = {8'h00, CARRIER_KHZ_OUT};
							ADDR_TARI_NS: next_prdata = {17'h00000, FIRST_TARI_NS_OUT};
							default: next_prdata = 32'h00000000;
						endcase
					end
				end
			end
			PDT_DONE: begin
				next_state = PDT_IDLE;
				next_pslverr = 1'b0;
				wr_fire = PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0] && !PSLVERR_OUT;
				if (wr_fire && mem_hit) begin
					mbus.we = 1'b1;
				end
				if (wr_fire && PADDR_IN == ADDR_CTRL) begin
					next_ctrl = PWDATA_IN[2:0];
				end
			end
			default: next_state = PDT_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state <= PDT_IDLE;
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT <= 32'h00000000;
			ctrl <= CTRL_RST;
		end else if (CE_IN) begin
			state <= next_state;
			PREADY_OUT <= next_pready;
			PSLVERR_OUT <= next_pslverr;
			PRDATA_OUT <= next_prdata;
			ctrl <= next_ctrl;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);

	sequence s_setup;
		state == PDT_IDLE && PSEL_IN && !PENABLE_IN && CE_IN;
	endsequence

	sequence s_write(logic [7:0] addr);
		CE_IN && state == PDT_DONE && PSEL_IN && PENABLE_IN && PWRITE_IN
			&& PSTRB_IN[0] && !PSLVERR_OUT && PADDR_IN == addr;
	endsequence

	a_apb_one_wait: assert property (s_setup ##1 CE_IN |-> !PREADY_OUT ##1 PREADY_OUT)
		else $error("APB answer not given after exactly one wait state");

	a_tari_range_flag: assert property (
		CE_IN && (first_tari_high_len < TARI_CODE_MIN || first_tari_high_len > TARI_CODE_MAX)
		|=> CFG_ERR_OUT[ST_TARI_RANGE])
		else $error("First Tari code outside legal range not flagged");

	a_tari_step_len: assert property (
		CE_IN && tari_mode == TARI_12US5
		|=> FIRST_TARI_NS_OUT == 15'($past(first_tari_high_len)) * 15'h0064)
		else $error("First Tari length does not use 100 ns steps");

	a_ref_illegal: assert property (
		CE_IN && pll_ref_divider_sel[2] == 1'b0 |=> CFG_ERR_OUT[ST_REF_ILLEGAL])
		else $error("Forbidden reference select not flagged");

	a_main_ratio: assert property (
		!RST_IN && CE_IN |=> MAIN_RATIO_OUT == 17'($past(main_div_b_count)) * 17'h00020
			+ 17'($past(main_div_a_count)) * 17'h00021)
		else $error("Main divider ratio wrong");

	a_main_a_low: assert property (s_write(8'h64) |=> main_div_a_count[7:0] ==
		$past(PWDATA_IN[7:0]))
		else $error("Main A low byte not taken from its register");

	a_aux_b_low: assert property (s_write(8'h6c) |=> aux_div_b_count[5:0] ==
		$past(PWDATA_IN[7:2]) && aux_div_a_count[9:8] == $past(PWDATA_IN[1:0]))
		else $error("Auxiliary B low or A high bits misplaced");

	a_aux_a_low: assert property (s_write(8'h70) |=> aux_div_a_count[7:0] ==
		$past(PWDATA_IN[7:0]))
		else $error("Auxiliary A low byte not taken from its register");

	a_carrier_khz: assert property (
		!RST_IN && CE_IN && pll_ref_divider_sel == REF_50K && !ctrl[CTRL_AUX_SEL]
		|=> CARRIER_KHZ_OUT == 24'h000032 * 24'($past(next_main_ratio)))
		else $error("Carrier does not follow reference times main ratio");

	a_aux_ratio: assert property (
		!RST_IN && CE_IN |=> AUX_RATIO_OUT == 17'($past(aux_div_b_count)) * 17'h00020
			+ 17'($past(aux_div_a_count)) * 17'h00021)
		else $error("Auxiliary divider ratio wrong");

	a_main_b_high: assert property (s_write(8'h5c) |=> main_div_b_count[9:6] ==
		$past(PWDATA_IN[3:0]) && pll_ref_divider_sel == $past(PWDATA_IN[6:4]))
		else $error("Main B high bits or reference select misplaced");

	a_main_b_low: assert property (s_write(8'h60) |=> main_div_b_count[5:0] ==
		$past(PWDATA_IN[7:2]) && main_div_a_count[9:8] == $past(PWDATA_IN[1:0]))
		else $error("Main B low or A high bits misplaced");

	a_aux_b_high: assert property (s_write(8'h68) |=> aux_div_b_count[9:6] ==
		$past(PWDATA_IN[3:0]))
		else $error("Auxiliary B high bits misplaced");

	a_tari_code_store: assert property (s_write(8'h58) |=> first_tari_high_len ==
		$past(PWDATA_IN[7:0]))
		else $error("First Tari code not taken from its register");

	a_ref_zero_carrier: assert property (
		!RST_IN && CE_IN && pll_ref_divider_sel[2] == 1'b0 |=> CARRIER_KHZ_OUT == 24'h000000)
		else $error("Carrier not zero for a forbidden reference select");

	a_unmapped_err: assert property (
		CE_IN && state == PDT_FETCH && !(mem_hit || own_hit) |=> PREADY_OUT && PSLVERR_OUT)
		else $error("Unmapped access answered without an error");
endmodule

// *** hw/pdt_pkg.sv ***
// Purpose: Constants for the PLL divider and first-Tari configuration registers.
// Assumes: APB with 32-bit data; documented registers sit at byte address index*4.
// Notes: Results are registered one cycle after a register changes.
package pdt_pkg;
	localparam int PDT_AW = 8;
	localparam int PDT_DW = 32;
	localparam int PDT_NREG = 7;
	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_FIRST_TARI = 6'h16;
	localparam logic [5:0] IDX_MAIN_REF_B = 6'h17;
	localparam logic [5:0] IDX_MAIN_B_A = 6'h18;
	localparam logic [5:0] IDX_MAIN_A = 6'h19;
	localparam logic [5:0] IDX_AUX_B = 6'h1a;
	localparam logic [5:0] IDX_AUX_B_A = 6'h1b;
	localparam logic [5:0] IDX_AUX_A = 6'h1c;
	// Values after reset, entry 0 (index 16h) in the low byte.
	localparam logic [55:0] PDT_RST_IMAGE = {8'h18, 8'h61, 8'h04, 8'hfc, 8'h68, 8'h64, 8'h7e};
	// Block-level registers.
	localparam logic [7:0] ADDR_CTRL = 8'h80;
	localparam logic [7:0] ADDR_STATUS = 8'h84;
	localparam logic [7:0] ADDR_MAIN_RATIO = 8'h88;
	localparam logic [7:0] ADDR_AUX_RATIO = 8'h8c;
	localparam logic [7:0] ADDR_CARRIER = 8'h90;
	localparam logic [7:0] ADDR_TARI_NS = 8'h94;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam int CTRL_AUX_SEL = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int ST_TARI_RANGE = 0;
	localparam int ST_REF_ILLEGAL = 1;
	localparam int ST_RSV_SET = 2;
	localparam int ST_MODE_ILLEGAL = 3;
	localparam int REF_LSB = 4;
	localparam int RSV_BIT = 7;
	localparam logic [7:0] TARI_CODE_MIN = 8'h5f;
	localparam logic [7:0] TARI_CODE_MAX = 8'h9d;
	localparam logic [1:0] TARI_6US25 = 2'h0;
	localparam logic [1:0] TARI_12US5 = 2'h1;
	localparam logic [1:0] TARI_25US = 2'h2;
	localparam logic [7:0] STEP_NS_6US25 = 8'h32;
	localparam logic [7:0] STEP_NS_12US5 = 8'h64;
	localparam logic [7:0] STEP_NS_25US = 8'hc8;
	localparam logic [2:0] REF_125K = 3'h4;
	localparam logic [2:0] REF_100K = 3'h5;
	localparam logic [2:0] REF_50K = 3'h6;
	localparam logic [2:0] REF_25K = 3'h7;
	localparam logic [6:0] REF_KHZ_125 = 7'h7d;
	localparam logic [6:0] REF_KHZ_100 = 7'h64;
	localparam logic [6:0] REF_KHZ_50 = 7'h32;
	localparam logic [6:0] REF_KHZ_25 = 7'h19;
	localparam logic [16:0] PRESC_LOW = 17'h00020;
	localparam logic [16:0] PRESC_HIGH = 17'h00021;
	typedef enum logic [2:0] {
		PDT_IDLE = 3'b001,
		PDT_FETCH = 3'b010,
		PDT_DONE = 3'b100
	} pdt_apb_e;
endpackage

// *** hw/pdt_mem_if.sv ***
// Purpose: Connects the register control logic to the register storage.
// Assumes: One clock; en freezes the storage.
// Notes: image shows every stored byte at once for the result logic.
`timescale 1ns/100ps
interface pdt_mem_if;
	logic en;
	logic we;
	logic [2:0] waddr;
	logic [7:0] wdata;
	logic [2:0] raddr;
	logic [7:0] rdata;
	logic [55:0] image;
	modport ctrl (output en, we, waddr, wdata, raddr, input rdata, image);
	modport mem (input en, we, waddr, wdata, raddr, output rdata, image);
endinterface

// *** hw/pdt_regmem.sv ***
// Purpose: Seven byte-wide configuration registers with a registered read port.
// Assumes: Writes and reads are issued by the control logic on the same clock.
// Notes: Read data appear one enabled edge after raddr.
`timescale 1ns/100ps
module pdt_regmem (
	input wire logic clk_in, // Clock.
	input wire logic rst_in, // Asynchronous reset, active high.
	pdt_mem_if.mem bus // Storage side.
);
	import pdt_pkg::*;

	logic [55:0] next_image;
	logic [55:0] image;
	logic [7:0] next_rdata;
	logic [7:0] rdata;

	genvar gi;
	generate
		for (gi = 0; gi < PDT_NREG; gi++) begin : g_entry
			always_comb begin
				next_image[gi*8 +: 8] = image[gi*8 +: 8];
				if (bus.we && bus.waddr == 3'(gi)) begin
					next_image[gi*8 +: 8] = bus.wdata;
				end
			end
		end
	endgenerate

	always_comb begin
		next_rdata = 8'h00;
		if (bus.raddr < 3'(PDT_NREG)) begin
			next_rdata = image[bus.raddr*8 +: 8];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			image <= PDT_RST_IMAGE;
			rdata <= 8'h00;
		end else if (bus.en) begin
			image <= next_image;
			rdata <= next_rdata;
		end
	end

	assign bus.rdata = rdata;
	assign bus.image = image;
endmodule

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the PLL divider and first-Tari register bank.
// Assumes: APB master with one transfer at a time; clock enable held high.
// Notes: Expected figures are worked out here from the register layout.
`timescale 1ns/100ps
module tb_top;
	import pdt_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	logic [16:0] main_ratio;
	logic [16:0] aux_ratio;
	logic [23:0] carrier;
	logic [14:0] tari_ns;
	logic [3:0] cfg_err;
	int errors = 0;
	int checked = 0;
	logic [31:0] rd_data;
	logic rd_err;
	pdt_regs i_pdt_regs (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PSTRB_IN(pstrb), .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
		.MAIN_RATIO_OUT(main_ratio), .AUX_RATIO_OUT(aux_ratio), .CARRIER_KHZ_OUT(carrier),
		.FIRST_TARI_NS_OUT(tari_ns), .CFG_ERR_OUT(cfg_err));
	initial begin
		forever #50 clk = ~clk;
	end
	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
		input logic [3:0] strb);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		pstrb <= strb;
		@(posedge clk);
		penable <= 1'b1;
		// Waits for the answer as long as it takes; only the watchdog ends a hang.
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		chk("pready", 1, pready);
		chk("pready wait", 2, n);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		apb(1'b1, addr, {24'h0, data}, 4'h1);
		repeat (2) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string name);
		apb(1'b0, addr, 32'h0, 4'h0);
		chk(name, exp, rd_data);
	endtask
	function automatic logic [16:0] ratio(input logic [9:0] b, input logic [9:0] a);
		return 17'(b) * 17'd32 + 17'(a) * 17'd33;
	endfunction
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [7:0] rv [7];
		rv = '{8'h7e, 8'h64, 8'h68, 8'hfc, 8'h04, 8'h61, 8'h18};
		for (int i = 0; i < 7; i++) begin
			rd({6'(IDX_FIRST_TARI + i), 2'b00}, {24'h0, rv[i]}, "reset value");
			chk("read err", 0, rd_err);
		end
		chk("main ratio", ratio(10'h11a, 10'h0fc), main_ratio);
		chk("aux ratio", ratio(10'h118, 10'h118), aux_ratio);
		chk("carrier", 50 * 17340, carrier);
		chk("tari ns", 126 * 50, tari_ns);
		chk("cfg err", 0, cfg_err);
		$display("test reset done");
	endtask
	task automatic t_main;
		logic [2:0] code [4];
		int khz [4];
		code = '{REF_125K, REF_100K, REF_50K, REF_25K};
		khz = '{125, 100, 50, 25};
		wr(8'h5c, 8'h66);
		wr(8'h60, 8'h50);
		wr(8'h64, 8'h86);
		chk("main ratio", 17350, main_ratio);
		rd(8'h60, 32'h50, "main b low");
		for (int i = 0; i < 4; i++) begin
			wr(8'h5c, {1'b0, code[i], 4'h6});
			chk("carrier", khz[i] * 17350, carrier);
		end
		wr(8'h5c, 8'h36);
		chk("bad ref err", 4'h2, cfg_err);
		chk("bad ref carrier", 0, carrier);
		wr(8'h5c, 8'he6);
		chk("reserved err", 4'h4, cfg_err);
		wr(8'h5c, 8'h66);
		chk("carrier 50k", 867500, carrier);
		$display("test main done");
	endtask
	task automatic t_aux;
		wr(8'h68, 8'h0f);
		wr(8'h6c, 8'hff);
		wr(8'h70, 8'hff);
		chk("aux ratio max", 66495, aux_ratio);
		wr(8'h6c, 8'h02);
		wr(8'h70, 8'h01);
		chk("aux ratio", ratio(10'h3c0, 10'h201), aux_ratio);
		wr(ADDR_CTRL, 8'h01);
		chk("aux carrier", 50 * ratio(10'h3c0, 10'h201), carrier);
		chk("main kept", 17350, main_ratio);
		wr(8'h68, 8'h1f);
		chk("aux reserved", 4'h4, cfg_err);
		wr(8'h68, 8'h0f);
		wr(ADDR_CTRL, 8'h00);
		$display("test aux done");
	endtask
	task automatic t_tari;
		logic [7:0] cv [4];
		int st [3];
		cv = '{8'h5f, 8'h9d, 8'h5e, 8'h9e};
		st = '{50, 100, 200};
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_CTRL, {5'h0, 2'(m), 1'b0});
			for (int i = 0; i < 4; i++) begin
				wr(8'h58, cv[i]);
				chk("tari ns", cv[i] * st[m], tari_ns);
				chk("tari range", {3'h0, i > 1}, cfg_err);
			end
		end
		wr(8'h58, 8'h80);
		wr(ADDR_CTRL, 8'h06);
		chk("mode err", 4'h8, cfg_err);
		wr(ADDR_CTRL, 8'h00);
		$display("test tari done");
	endtask
	task automatic t_bus;
		rd(8'h74, 0, "unmapped data");
		chk("unmapped err", 1, rd_err);
		rd(8'h59, 0, "misaligned data");
		chk("misaligned err", 1, rd_err);
		apb(1'b1, ADDR_MAIN_RATIO, 32'h0, 4'h1);
		chk("ro write err", 1, rd_err);
		apb(1'b1, 8'h64, 32'h00, 4'h0);
		repeat (2) @(posedge clk);
		rd(ADDR_MAIN_RATIO, 17350, "strobe off ratio");
		rd(ADDR_STATUS, 0, "status");
		rd(8'h58, 8'h80, "tari code");
		rd(ADDR_CTRL, 0, "ctrl read");
		rd(ADDR_AUX_RATIO, ratio(10'h3c0, 10'h201), "aux ratio read");
		rd(ADDR_CARRIER, 867500, "carrier read");
		rd(ADDR_TARI_NS, 128 * 50, "tari ns read");
		$display("test bus done");
	endtask
	// ----------------------------------------
	// Main sequence and verdict
	// ----------------------------------------
	task automatic final_report;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		t_main();
		t_aux();
		t_tari();
		t_bus();
		final_report();
	end
	initial begin
		#5000000;
		errors++;
		final_report();
	end
endmodule
